// ===== core/flash_command_sequencer_consts.vh
`ifndef FLASH_COMMAND_SEQUENCER_CONSTS_VH
`define FLASH_COMMAND_SEQUENCER_CONSTS_VH
// ==================================================================
// Unlock field codes
`define UNLOCK_ENABLE      4'h3
`define UNLOCK_DISABLE     4'hC
// ==================================================================
// Operating modes
`define MODE_MCU           2'h0
`define MODE_SERIAL        2'h1
`define MODE_PARALLEL      2'h2
// ==================================================================
// Command addresses, low twelve bits
`define CMD_ADDR_A         12'h555
`define CMD_ADDR_B         12'hAAA
// Full-decoded locations
`define PROTECT_ADDR       16'hFF7F
`define ID_VENDOR_ADDR     16'hF000
`define ID_MACRO_ADDR      16'hF001
`define ID_SIZE_ADDR       16'hF002
// ==================================================================
// Command data bytes
`define DAT_UNLOCK1        8'hAA
`define DAT_UNLOCK2        8'h55
`define DAT_PROGRAM        8'hA0
`define DAT_ERASE_SETUP    8'h80
`define DAT_SECTOR_ERASE   8'h30
`define DAT_CHIP_ERASE     8'h10
`define DAT_ID_ENTRY       8'h90
`define DAT_ID_EXIT        8'hF0
`define DAT_PROTECT        8'hA5
`define DAT_PROTECT_VAL    8'h00
`define DAT_UNPROTECTED    8'hFF
`define DAT_PROTECTED      8'h00
// ==================================================================
// Area decode: lowest upper-nibble per mode
`define AREA_MCU_LOW       4'h1
`define AREA_LOWER_BANK_LOW     4'h9
`define AREA_UPPER_BANK_LOW     4'h8
// Lower bank seen 8000H above its real place
`define LOWER_BANK_OFFSET       16'h8000
// ==================================================================
// Toggle bit position
`define TOGGLE_BIT         6
// Timing
`define CLOCK_MHZ          100
`define PROG_TIME_US       40
`define PROG_CYCLES        (`PROG_TIME_US * `CLOCK_MHZ)
`define ERASE_TIME_MS      30
`define ERASE_CYCLES       (`ERASE_TIME_MS * 1000 * `CLOCK_MHZ)
`endif

// ===== core/flash_command_sequencer.v
// Operation
// - Sequences accepted only while unlock field holds 0011; reset value 1100 blocks.
// - Command addresses matched on low 12 bits; target, sector, protect decoded fully.
// - Upper nibble must fall in the mode and bank dependent flash area.
// - AA/555, 55/AAA, A0/555 then fourth write programs the target byte.
// - Byte program completes within 40 us of its last write.
// - Six-write sequence ending 30H erases the sector named by upper nibble.
// - Sector erase finishes within 30 ms of the sixth write.
// - Six-write sequence ending 10H to 555 erases the whole array.
// - New sequences ignored while an operation runs.
// - Busy reads return bit 6 inverted from previous read; stops when done.
// - First read after program, chip erase or protect returns toggle as 1.
// - AA/555, 55/AAA, 90/555 enters identification mode.
// - In identification mode F000, F001, F002, FF7F return codes, not array.
// - Size code maps 60,48,32,24,16,8,4 kbytes to 0E,0B,07,05,03,01,00.
// - Protection location reads FFH when unprotected, other value when protected.
// - Identification ends on single F0 write or AA, 55, F0 to 555.
// - AA, 55, A5 then 00 to FF7F sets read protection within 40 us.
// - Read protection cleared only by chip erase.
// - Protected: refuse parallel-mode reads, serial write and loader commands; serial mode only raises o_serial_cmd_block, commands still decoded.
// - Sector erase has no effect in parallel mode.
`timescale 1ns/100ps
`default_nettype none
`include "flash_command_sequencer_consts.vh"

module flash_command_sequencer #(
   parameter       SIZE_KB      = 60,
   parameter [7:0] VENDOR_CODE  = 8'h5A, // Arbitrary value
   parameter [7:0] MACRO_CODE   = 8'h3C, // Arbitrary value
   parameter       ERASE_CYCLES = `ERASE_CYCLES
) (
   // Clock and reset
   input  wire        i_clock,
   input  wire        i_rst,
   // Control bits
   input  wire [3:0]  i_cmd_exec_unlock_field,
   input  wire        i_upper_bank,
   input  wire [1:0]  i_mode,
   // CPU write cycle
   input  wire        i_wr,
   input  wire [15:0] i_addr,
   input  wire [7:0]  i_wdata,
   // CPU read cycle, array byte at i_addr
   input  wire        i_rd,
   input  wire [7:0]  i_array_data,
   // Read answer
   output reg  [7:0]  o_rdata,
   output reg         o_rvalid,
   // Array operation requests
   output reg         o_prog_req,
   output reg  [15:0] o_prog_addr,
   output reg  [7:0]  o_prog_data,
   output reg         o_sector_erase_req,
   output reg  [3:0]  o_sector,
   output reg         o_chip_erase_req,
   // Status
   output reg         o_busy,
   output reg         o_id_mode,
   output reg         o_protected,
   output reg         o_parallel_read_block,
   output reg         o_serial_cmd_block
);

   // ===============================================================
   // Decoder states
   localparam [2:0] S_IDLE   = 3'h0;
   localparam [2:0] S_UNL1   = 3'h1;
   localparam [2:0] S_UNL2   = 3'h2;
   localparam [2:0] S_PROG   = 3'h3;
   localparam [2:0] S_ERS1   = 3'h4;
   localparam [2:0] S_ERS2   = 3'h5;
   localparam [2:0] S_ERS3   = 3'h6;
   localparam [2:0] S_PROT   = 3'h7;

   // Operation kinds
   localparam [1:0] OP_PROG  = 2'h0;
   localparam [1:0] OP_SECT  = 2'h1;
   localparam [1:0] OP_CHIP  = 2'h2;
   localparam [1:0] OP_PROT  = 2'h3;

   // Counts load one short: the zero count is a busy cycle too
   localparam integer PROG_INT   = `PROG_CYCLES - 1;
   localparam integer ERASE_INT  = ERASE_CYCLES - 1;
   localparam [21:0]  PROG_LOAD  = PROG_INT[21:0];
   localparam [21:0]  ERASE_LOAD = ERASE_INT[21:0];

   // ===============================================================
   // Size code lookup
   // Unknown sizes fall back to the smallest code
   function [7:0] size_code;
      input integer kb;
      begin
         case (kb)
            60:      size_code = 8'h0E;
            48:      size_code = 8'h0B;
            32:      size_code = 8'h07;
            24:      size_code = 8'h05;
            16:      size_code = 8'h03;
            8:       size_code = 8'h01;
            default: size_code = 8'h00;
         endcase
      end
   endfunction

   // Low twelve address bits match with area check
   function cmd_hit;
      input [15:0] a;
      input [11:0] low;
      input        area;
      begin
         cmd_hit = area && (a[11:0] == low);
      end
   endfunction

   // Decoder and operation state
   reg  [2:0]  state;
   reg  [1:0]  op;
   reg  [21:0] count;
   reg         toggle;

   // ===============================================================
   // Area check and physical address
   reg  [3:0]  area_low;
   wire        in_area;
   wire [15:0] phys_addr;

   // Serial lower bank only reaches the low half of the array
   // Lower bank shifted down in serial mode
   // Area by mode
   always @* begin
      if (i_mode == `MODE_SERIAL)
         area_low = i_upper_bank ? `AREA_UPPER_BANK_LOW : `AREA_LOWER_BANK_LOW;
      else
         area_low = `AREA_MCU_LOW;
   end

   assign in_area   = (i_addr[15:12] >= area_low);
   assign phys_addr = (i_mode == `MODE_SERIAL && !i_upper_bank) ?
                      (i_addr - `LOWER_BANK_OFFSET) : i_addr;

   // Step matches, low twelve bits only
   // Low bits decode
   wire at_a  = cmd_hit(i_addr, `CMD_ADDR_A, in_area);
   wire at_b  = cmd_hit(i_addr, `CMD_ADDR_B, in_area);
   wire is_u1 = at_a && (i_wdata == `DAT_UNLOCK1);
   wire is_u2 = at_b && (i_wdata == `DAT_UNLOCK2);

   wire unlocked = (i_cmd_exec_unlock_field == `UNLOCK_ENABLE);
   // Writes while busy are dropped without touching the decoder
   // Busy blocks writes
   wire take_wr  = i_wr && unlocked && !o_busy;

   // ===============================================================
   // Sequence decoder
   // Any write that misses the expected step drops to idle, so a
   // stray store never leaves the decoder half armed.
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state              <= S_IDLE;
         op                 <= OP_PROG;
         count              <= 22'h000000;
         toggle             <= 1'b1;
         o_busy             <= 1'b0;
         o_id_mode          <= 1'b0;
         o_protected        <= 1'b0;
         o_prog_req         <= 1'b0;
         o_prog_addr        <= 16'h0000;
         o_prog_data        <= 8'h00;
         o_sector_erase_req <= 1'b0;
         o_sector           <= 4'h0;
         o_chip_erase_req   <= 1'b0;
      end else begin
         o_prog_req         <= 1'b0;
         o_sector_erase_req <= 1'b0;
         o_chip_erase_req   <= 1'b0;
         // Running operation countdown
         // Timed completion
         if (o_busy) begin
            if (count == 22'h000000) begin
               o_busy <= 1'b0;
               // Protection changes only when the operation ends
               // Protect lands at end
               if (op == OP_PROT)
                  o_protected <= 1'b1;
               if (op == OP_CHIP)
                  o_protected <= 1'b0;
            end else begin
               count <= count - 22'h000001;
            end
         end
         if (take_wr) begin
            state <= S_IDLE;
            case (state)
               S_IDLE: begin
                  if (is_u1)
                     state <= S_UNL1;
                  else if (i_wdata == `DAT_ID_EXIT)
                     o_id_mode <= 1'b0;
               end
               S_UNL1: begin
                  if (is_u2)
                     state <= S_UNL2;
               end
               S_UNL2: begin
                  if (at_a) begin
                     case (i_wdata)
                        `DAT_PROGRAM:     state <= S_PROG;
                        `DAT_ERASE_SETUP: state <= S_ERS1;
                        `DAT_PROTECT:     state <= S_PROT;
                        `DAT_ID_ENTRY:    o_id_mode <= 1'b1;
                        `DAT_ID_EXIT:     o_id_mode <= 1'b0;
                        default:          state <= S_IDLE;
                     endcase
                  end
               end
               S_PROG: begin
                  if (in_area) begin
                     o_prog_req  <= 1'b1;
                     o_prog_addr <= phys_addr;
                     o_prog_data <= i_wdata;
                     op          <= OP_PROG;
                     o_busy      <= 1'b1;
                     count       <= PROG_LOAD;
                     toggle      <= 1'b1;
                  end
               end
               S_ERS1: begin
                  if (is_u1)
                     state <= S_ERS2;
               end
               S_ERS2: begin
                  if (is_u2)
                     state <= S_ERS3;
               end
               S_ERS3: begin
                  if (at_a && i_wdata == `DAT_CHIP_ERASE) begin
                     o_chip_erase_req <= 1'b1;
                     op               <= OP_CHIP;
                     o_busy           <= 1'b1;
                     count            <= ERASE_LOAD;
                     toggle           <= 1'b1;
                  end
                  else if (in_area && i_wdata == `DAT_SECTOR_ERASE &&
                           i_mode != `MODE_PARALLEL) begin
                     o_sector_erase_req <= 1'b1;
                     o_sector           <= phys_addr[15:12];
                     op                 <= OP_SECT;
                     o_busy             <= 1'b1;
                     count              <= ERASE_LOAD;
                     toggle             <= 1'b1;
                  end
               end
               S_PROT: begin
                  if (i_addr == `PROTECT_ADDR &&
                      i_wdata == `DAT_PROTECT_VAL && in_area) begin
                     op     <= OP_PROT;
                     o_busy <= 1'b1;
                     count  <= PROG_LOAD;
                     toggle <= 1'b1;
                  end
               end
               default: state <= S_IDLE;
            endcase
         end
         // Toggle advances on each busy read
         // Toggle per read
         if (i_rd && o_busy)
            toggle <= ~toggle;
      end
   end

   // ===============================================================
   // Read answer
   // Registered so the CPU sees a fixed one-cycle latency.
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_rdata  <= 8'h00;
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= i_rd;
         if (i_rd) begin
            o_rdata <= i_array_data;
            // Refusal wins over the toggle so nothing leaks out
            // Parallel reads refused
            if (o_protected && i_mode == `MODE_PARALLEL)
               o_rdata <= 8'h00;
            else if (o_busy)
               o_rdata[`TOGGLE_BIT] <= toggle;
            else if (o_id_mode) begin
               // Full 16-bit compare, unlike the command steps
               case (i_addr)
                  `ID_VENDOR_ADDR: o_rdata <= VENDOR_CODE;
                  `ID_MACRO_ADDR:  o_rdata <= MACRO_CODE;
                  `ID_SIZE_ADDR:   o_rdata <= size_code(SIZE_KB);
                  `PROTECT_ADDR:   o_rdata <= o_protected ?
                                   `DAT_PROTECTED : `DAT_UNPROTECTED;
                  default:         o_rdata <= i_array_data;
               endcase
            end
         end
      end
   end

   // ===============================================================
   // Protection blocks for mode logic outside
   // Refusal flags
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_parallel_read_block <= 1'b0;
         o_serial_cmd_block    <= 1'b0;
      end else begin
         o_parallel_read_block <= o_protected &&
                                  (i_mode == `MODE_PARALLEL);
         o_serial_cmd_block    <= o_protected &&
                                  (i_mode == `MODE_SERIAL);
      end
   end

endmodule // flash_command_sequencer
`default_nettype wire

// ===== tb/flash_command_sequencer_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================================
// Port checks for the command sequencer
module flash_command_sequencer_assertions #(
   parameter ERASE_CYCLES = 50
) (
   // Single bits, grouped to keep the list short
   input wire        i_clock, i_rst, i_upper_bank, i_wr, i_rd,
   input wire        o_rvalid, o_prog_req, o_sector_erase_req,
   input wire        o_chip_erase_req, o_busy, o_id_mode, o_protected,
   input wire        o_parallel_read_block, o_serial_cmd_block,
   // Buses
   input wire [3:0]  i_cmd_exec_unlock_field, o_sector,
   input wire [1:0]  i_mode,
   input wire [15:0] i_addr, o_prog_addr,
   input wire [7:0]  i_wdata, i_array_data, o_rdata, o_prog_data
);
   reg        busy_q;
   reg        first;
   reg        chip_op;
   reg [31:0] cnt;
   reg [31:0] lim;
   wire       rise = o_busy & ~busy_q;
   wire       any_req = o_prog_req | o_sector_erase_req | o_chip_erase_req;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // Busy length, first busy read, kind of last operation
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         busy_q  <= 1'b0;
         first   <= 1'b0;
         chip_op <= 1'b0;
         cnt     <= 32'h0;
         lim     <= 32'h0;
      end else begin
         busy_q <= o_busy;
         cnt    <= rise ? 32'h1 : cnt + 32'h1;
         first  <= rise | (first & ~o_rvalid);
         if (rise)
            lim <= (o_sector_erase_req | o_chip_erase_req) ?
                   ERASE_CYCLES : 4000;
         if (any_req)
            chip_op <= o_chip_erase_req;
      end
   end
   AST_LOCKED: assert property (i_wr && i_cmd_exec_unlock_field != 4'h3
      |=> !any_req) else $error("request after a locked write");
   AST_PROG_DATA: assert property (o_prog_req |-> o_busy && $past(i_wr)
      && o_prog_data == $past(i_wdata)) else $error("program byte wrong");
   AST_BUSY_REFUSE: assert property ($past(o_busy) |-> !any_req)
      else $error("request while busy");
   AST_BUSY_TIME: assert property (o_busy && busy_q |-> cnt <= lim)
      else $error("operation overran its time");
   AST_FIRST_TOGGLE: assert property (o_rvalid && first && o_busy
      |-> o_rdata[6]) else $error("first busy read not 1");
   AST_PAR_REFUSE: assert property (o_rvalid && $past(o_parallel_read_block)
      |-> o_rdata == 8'h00) else $error("protected read not refused");
   AST_CLEAR_BY_CHIP: assert property ($fell(o_protected) |-> chip_op)
      else $error("protection cleared without chip erase");
   AST_SET_AT_END: assert property ($rose(o_protected) |-> $fell(o_busy))
      else $error("protection set outside completion");
   AST_SECTOR_MODE: assert property (o_sector_erase_req
      |-> $past(i_mode) != 2'h2) else $error("sector erase in parallel mode");
   AST_READ_ANSWER: assert property (o_rvalid == $past(i_rd))
      else $error("read answer timing wrong");
endmodule // flash_command_sequencer_assertions
`default_nettype wire

// ===== tb/cpu_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================================
// CPU side: one-cycle write and read strobes
module cpu_bus_model (
   // Clock
   input  wire              i_clock,
   // Bus cycle
   output var logic         o_wr,
   output var logic         o_rd,
   output var logic  [15:0] o_addr,
   output var logic  [7:0]  o_wdata,
   // Array byte at the current address
   output wire       [7:0]  o_array_data
);
   // Pattern differs from one address to the next
   assign o_array_data = o_addr[7:0] ^ {o_addr[15:12], 4'hA};
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 16'h0;
      o_wdata = 8'h0;
   end
   // Released lines show the inverse, never a stale value
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clock);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clock);
      o_wr <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask
   task automatic rd(input logic [15:0] a);
      @(posedge i_clock);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clock);
      o_rd <= 1'b0;
      o_addr <= ~a;
   endtask
endmodule // cpu_bus_model
`default_nettype wire

// ===== tb/test_flash_command_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================================
// Bench for the command sequencer
module test_flash_command_sequencer;
   logic        i_clock, i_rst, i_upper_bank;
   logic [3:0]  i_cmd_exec_unlock_field;
   logic [1:0]  i_mode;
   wire         i_wr, i_rd, o_rvalid, o_prog_req, o_sector_erase_req;
   wire         o_chip_erase_req, o_busy, o_id_mode, o_protected;
   wire         o_parallel_read_block, o_serial_cmd_block;
   wire [15:0]  i_addr, o_prog_addr;
   wire [7:0]   i_wdata, i_array_data, o_rdata, o_prog_data;
   wire [3:0]   o_sector;
   logic [23:0] rq[$];
   logic [23:0] nq[$];
   logic [31:0] seed = 32'd33179;
   logic [31:0] r;
   logic [15:0] a;
   logic [7:0]  d;
   logic [3:0]  h;
   logic        tog;
   int          errors = 0;
   int          n_tests = 0;
   int          ticks = 0;
   // ID codes below are arbitrary
   flash_command_sequencer #(.SIZE_KB(32), .VENDOR_CODE(8'hA7),
      .MACRO_CODE(8'h6C), .ERASE_CYCLES(50)) dut (
      .i_clock(i_clock), .i_rst(i_rst), .i_upper_bank(i_upper_bank),
      .i_cmd_exec_unlock_field(i_cmd_exec_unlock_field), .i_mode(i_mode),
      .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata), .i_rd(i_rd),
      .i_array_data(i_array_data), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
      .o_prog_req(o_prog_req), .o_prog_addr(o_prog_addr),
      .o_prog_data(o_prog_data), .o_sector_erase_req(o_sector_erase_req),
      .o_sector(o_sector), .o_chip_erase_req(o_chip_erase_req),
      .o_busy(o_busy), .o_id_mode(o_id_mode), .o_protected(o_protected),
      .o_parallel_read_block(o_parallel_read_block),
      .o_serial_cmd_block(o_serial_cmd_block));
   cpu_bus_model cpu (.i_clock(i_clock), .o_wr(i_wr), .o_rd(i_rd),
      .o_addr(i_addr), .o_wdata(i_wdata), .o_array_data(i_array_data));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] arr(input logic [15:0] x);
      return x[7:0] ^ {x[15:12], 4'hA};
   endfunction
   task automatic chk(input string s, input logic [23:0] e, g);
      n_tests++;
      if (e !== g) begin
         errors++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic rd(input logic [15:0] x, input logic [7:0] e);
      rq.push_back({16'h0, e});
      cpu.rd(x);
   endtask
   // Reads while busy: bit 6 starts at 1 and flips each read
   task automatic rd_busy(input logic [15:0] x);
      tog = 1'b1;
      repeat (3) begin
         d = arr(x);
         rd(x, {d[7], tog, d[5:0]});
         tog = ~tog;
      end
   endtask
   task automatic cmd(input int n, input logic [3:0] hi,
                      input logic [7:0] d3, input logic [15:0] al,
                      input logic [7:0] dl);
      cpu.wr({hi, 12'h555}, 8'hAA);
      cpu.wr({hi, 12'hAAA}, 8'h55);
      cpu.wr({hi, 12'h555}, d3);
      if (n == 6) begin
         cpu.wr({hi, 12'h555}, 8'hAA);
         cpu.wr({hi, 12'hAAA}, 8'h55);
      end
      if (n > 3)
         cpu.wr(al, dl);
   endtask
   // poll until the operation is over, bounded
   task automatic idle(input int lim);
      int c;
      c = 0;
      @(negedge i_clock);
      while (o_busy !== 1'b0 && c <= lim) begin
         @(negedge i_clock);
         c++;
      end
      chk("busy_time", 24'h1, {23'h0, c <= lim});
   endtask
   task automatic summarize();
      if (errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Every answer and request is matched against the oldest note
   always @(negedge i_clock) begin
      if (o_rvalid === 1'b1)
         chk("rdata", rq.size() ? rq.pop_front() : 24'hFFFFFF,
             {16'h0, o_rdata});
      if ((o_prog_req | o_sector_erase_req | o_chip_erase_req) !== 1'b0)
         chk("request", nq.size() ? nq.pop_front() : 24'hFFFFFF,
             o_prog_req ? {o_prog_addr, o_prog_data} : o_sector_erase_req ?
             {20'h5EC00, o_sector} : 24'hC41E00);
   end
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   // Cut a hang short
   always @(posedge i_clock) begin
      ticks++;
      if (ticks == 20000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      i_rst = 1'b1;
      i_cmd_exec_unlock_field = 4'hC;
      i_mode = 2'h0;
      i_upper_bank = 1'b0;
      repeat (16) @(posedge i_clock);
      i_rst <= 1'b0;
      r = rnd();
      h = (r[31:28] == 4'h0) ? 4'h1 : r[31:28];
      a = {h, r[11:0]};
      d = r[19:12];
      cmd(4, h, 8'hA0, a, d);
      i_cmd_exec_unlock_field <= 4'h3;
      cmd(4, h, 8'h77, a, d);
      cmd(4, 4'h0, 8'hA0, {4'h0, a[11:0]}, d);
      nq.push_back({a, d});
      cmd(4, h, 8'hA0, a, d);
      rd_busy(a);
      // no byte is rewritten, so the refused one aims elsewhere
      cmd(4, h, 8'hA0, a ^ 16'h0001, ~d);
      idle(4000);
      rd(a, arr(a));
      // Sector erase: MCU, upper bank, lower bank, parallel
      for (int m = 0; m < 4; m++) begin
         r = rnd();
         h = 4'h9 | {1'b0, r[2:0]};
         i_mode <= (m == 0) ? 2'h0 : (m == 3) ? 2'h2 : 2'h1;
         i_upper_bank <= (m == 1);
         if (m < 3)
            nq.push_back({20'h5EC00, (m == 2) ? h - 4'h8 : h});
         cmd(6, h, 8'h80, {h, r[11:0]}, 8'h30);
         idle(50);
      end
      i_mode <= 2'h0;
      // Identification entry, code reads, both exits
      for (int k = 0; k < 2; k++) begin
         cmd(3, h, 8'h90, 16'h0, 8'h0);
         @(negedge i_clock);
         chk("id_mode", 24'h1, {23'h0, o_id_mode});
         rd(16'hF000, 8'hA7);
         rd(16'hF001, 8'h6C);
         rd(16'hF002, 8'h07);
         rd(16'hFF7F, 8'hFF);
         if (k == 0)
            cpu.wr(a, 8'hF0);
         else
            cmd(3, h, 8'hF0, 16'h0, 8'h0);
         @(negedge i_clock);
         chk("id_exit", 24'h0, {23'h0, o_id_mode});
      end
      // Protect from serial mode, upper bank chosen first
      i_mode <= 2'h1;
      i_upper_bank <= 1'b1;
      cmd(4, h, 8'hA5, 16'hFF7F, 8'h00);
      rd_busy(a);
      idle(4000);
      chk("protected", 24'h1, {23'h0, o_protected});
      i_mode <= 2'h0;
      cmd(3, h, 8'h90, 16'h0, 8'h0);
      rd(16'hFF7F, 8'h00);
      cpu.wr(a, 8'hF0);
      i_mode <= 2'h2;
      rd(a, 8'h00);
      @(negedge i_clock);
      chk("blocks", 24'h2, {22'h0, o_parallel_read_block,
          o_serial_cmd_block});
      i_mode <= 2'h1;
      repeat (2) @(negedge i_clock);
      chk("blocks", 24'h1, {22'h0, o_parallel_read_block,
          o_serial_cmd_block});
      i_mode <= 2'h0;
      nq.push_back(24'hC41E00);
      cmd(6, h, 8'h80, {h, 12'h555}, 8'h10);
      idle(50);
      chk("unprotected", 24'h0, {23'h0, o_protected});
      repeat (2) @(negedge i_clock);
      chk("notes_left", 24'h0, 24'(rq.size() + nq.size()));
      summarize();
   end
endmodule // test_flash_command_sequencer
bind flash_command_sequencer flash_command_sequencer_assertions #(
   .ERASE_CYCLES(ERASE_CYCLES)) chk_i (
   .i_clock(i_clock), .i_rst(i_rst), .i_upper_bank(i_upper_bank),
   .i_wr(i_wr), .i_rd(i_rd), .o_rvalid(o_rvalid), .o_prog_req(o_prog_req),
   .o_sector_erase_req(o_sector_erase_req), .o_busy(o_busy),
   .o_chip_erase_req(o_chip_erase_req), .o_id_mode(o_id_mode),
   .o_protected(o_protected), .o_parallel_read_block(o_parallel_read_block),
   .o_serial_cmd_block(o_serial_cmd_block), .o_sector(o_sector),
   .i_cmd_exec_unlock_field(i_cmd_exec_unlock_field), .i_mode(i_mode),
   .i_addr(i_addr), .o_prog_addr(o_prog_addr), .i_wdata(i_wdata),
   .i_array_data(i_array_data), .o_rdata(o_rdata),
   .o_prog_data(o_prog_data));
`default_nettype wire
